// *** rtl/au_params.svh ***
`ifndef AU_PARAMS_SVH
`define AU_PARAMS_SVH
`define AU_OFF_BYTE0   12'h000
`define AU_OFF_BYTE1   12'h004
`define AU_OFF_BYTE2   12'h008
`define AU_OFF_BYTE3   12'h00c
`define AU_OFF_BYTE4   12'h010
`define AU_OFF_BYTE5   12'h014
`define AU_OFF_STATUS  12'h018
`define AU_ERR_BIT     7
`define AU_OVF_BIT     6
`define AU_STATUS_RST  8'h00
`define AU_CYC_DIV32   5'd17
`define AU_CYC_DIV16   5'd9
`define AU_CYC_MUL     5'd11
`endif

// *** rtl/au_pkg.sv ***
package au_pkg;
    typedef enum logic [1:0] {AU_OP_DIV32, AU_OP_DIV16, AU_OP_MUL} au_op_t;
    typedef enum logic [2:0] {
        AU_SEQ_IDLE, AU_SEQ_W0, AU_SEQ_W01, AU_SEQ_W012, AU_SEQ_W0123,
        AU_SEQ_W01234, AU_SEQ_W014, AU_SEQ_W04
    } au_seq_t;
    typedef enum logic [1:0] {AU_SEQ_W041_X = 2'd0, AU_SEQ_UNUSED = 2'd1} au_aux_t;
endpackage

// *** rtl/au_engine.sv ***
`timescale 1ns/1ps
`include "au_params.svh"
// iterative unsigned divide / multiply core, two quotient bits per clock
module au_engine
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         start,
    input  wire au_pkg::au_op_t op,
    input  wire logic [31:0]  opa,
    input  wire logic [15:0]  opb,
    output logic              done,
    output logic [31:0]       res_q,
    output logic [15:0]       res_r,
    output logic              ovf
);
    import au_pkg::*;

    logic [4:0]  cnt_reg;
    logic [4:0]  bits_reg;
    logic        busy_reg;
    au_op_t      op_reg;
    logic [31:0] q_reg;
    logic [16:0] r_reg;
    logic [15:0] d_reg;
    logic [31:0] acc_reg;
    logic [15:0] mcand_reg;
    logic [16:0] r_shift;
    logic [16:0] r_sub;
    logic [16:0] r_mid;
    logic [16:0] r_shift2;
    logic [16:0] r_sub2;
    logic [16:0] r_next;
    logic [1:0]  q_bits;

    // two restoring steps per clock so the quotient fits the fixed latency
    assign r_shift  = {r_reg[15:0], q_reg[31]};
    assign r_sub    = r_shift - {1'b0, d_reg};
    assign r_mid    = r_sub[16] ? r_shift : r_sub;
    assign r_shift2 = {r_mid[15:0], q_reg[30]};
    assign r_sub2   = r_shift2 - {1'b0, d_reg};
    assign r_next   = r_sub2[16] ? r_shift2 : r_sub2;
    assign q_bits   = {~r_sub[16], ~r_sub2[16]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_reg <= 1'b0;
            cnt_reg  <= 5'd0;
            done     <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                busy_reg <= 1'b1;
                cnt_reg  <= (op == AU_OP_DIV32) ? `AU_CYC_DIV32 - 5'd1 :
                            (op == AU_OP_DIV16) ? `AU_CYC_DIV16 - 5'd1 :
                                                  `AU_CYC_MUL - 5'd1;
            end
            else if (busy_reg)
            begin
                if (cnt_reg == 5'd1)
                begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                end
                cnt_reg <= cnt_reg - 5'd1;
            end
        end
    end

    always_ff @(posedge pclk)
    begin
        if (start)
        begin
            op_reg    <= op;
            q_reg     <= (op == AU_OP_DIV32) ? opa : {opa[15:0], 16'h0000};
            r_reg     <= 17'h00000;
            d_reg     <= opb;
            acc_reg   <= 32'h00000000;
            mcand_reg <= opa[15:0];
            bits_reg  <= (op == AU_OP_DIV32) ? `AU_CYC_DIV32 - 5'd2 :
                         (op == AU_OP_DIV16) ? `AU_CYC_DIV16 - 5'd2 : 5'd0;
        end
        else if (busy_reg && bits_reg != 5'h1f)
        begin
            if (op_reg == AU_OP_MUL)
            begin
                acc_reg  <= {16'h0000, mcand_reg} * {16'h0000, d_reg};
                bits_reg <= 5'h1f;
            end
            else
            begin
                r_reg <= r_next;
                q_reg <= {q_reg[29:0], q_bits};
                bits_reg <= (bits_reg == 5'd0) ? 5'h1f : bits_reg - 5'd1;
            end
        end
    end

    always_comb
    begin
        if (op_reg == AU_OP_MUL)
        begin
            res_q = acc_reg;
            res_r = 16'h0000;
            ovf   = (acc_reg[31:16] != 16'h0000);
        end
        else
        begin
            res_q = (op_reg == AU_OP_DIV32) ? q_reg : {16'h0000, q_reg[15:0]};
            res_r = r_reg[15:0];
            ovf   = (d_reg == 16'h0000);
        end
    end
endmodule // au_engine

// *** rtl/au_top.sv ***
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "au_params.svh"
module au_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy
);
    import au_pkg::*;

    localparam logic [7:0] status_rst_val = `AU_STATUS_RST;

    logic [7:0]  data_reg [0:5];
    logic        err_reg;
    logic        ovf_reg;
    logic        busy_reg;
    au_seq_t     seq_reg;
    logic        start;
    au_op_t      start_op;
    logic        eng_done;
    logic [31:0] eng_q;
    logic [15:0] eng_r;
    logic        eng_ovf;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [2:0]  idx;
    logic        is_data;
    logic        is_stat;
    logic        mul_pend_reg;

    assign pready  = 1'b1;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign rd      = acc & ~pwrite;
    assign is_data = (paddr <= `AU_OFF_BYTE5) && (paddr[1:0] == 2'b00);
    assign is_stat = (paddr == `AU_OFF_STATUS);
    assign pslverr = acc & ~is_data & ~is_stat;
    assign idx     = paddr[4:2];
    assign busy    = busy_reg;

    // start on byte5 ending a known order
    always_comb
    begin
        start    = 1'b0;
        start_op = AU_OP_DIV32;
        if (wr && is_data && !busy_reg && idx == 3'd5)
        begin
            if (seq_reg == AU_SEQ_W01234)
            begin
                start = 1'b1;
            end
            else if (seq_reg == AU_SEQ_W014)
            begin
                start    = 1'b1;
                start_op = AU_OP_DIV16;
            end
            else if (seq_reg == AU_SEQ_W04 && mul_pend_reg)
            begin
                start    = 1'b1;
                start_op = AU_OP_MUL;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_reg      <= AU_SEQ_IDLE;
            mul_pend_reg <= 1'b0;
        end
        else if (wr && is_data && !busy_reg)
        begin
            mul_pend_reg <= 1'b0;
            case (idx)
                3'd0: seq_reg <= AU_SEQ_W0;
                3'd1:
                begin
                    if (seq_reg == AU_SEQ_W0)
                        seq_reg <= AU_SEQ_W01;
                    else if (seq_reg == AU_SEQ_W04)
                    begin
                        seq_reg      <= AU_SEQ_W04;
                        mul_pend_reg <= 1'b1;
                    end
                    else
                        seq_reg <= AU_SEQ_IDLE;
                end
                3'd2: seq_reg <= (seq_reg == AU_SEQ_W01) ? AU_SEQ_W012 : AU_SEQ_IDLE;
                3'd3: seq_reg <= (seq_reg == AU_SEQ_W012) ? AU_SEQ_W0123 : AU_SEQ_IDLE;
                3'd4:
                begin
                    if (seq_reg == AU_SEQ_W0123)
                        seq_reg <= AU_SEQ_W01234;
                    else if (seq_reg == AU_SEQ_W01)
                        seq_reg <= AU_SEQ_W014;
                    else if (seq_reg == AU_SEQ_W0)
                        seq_reg <= AU_SEQ_W04;
                    else
                        seq_reg <= AU_SEQ_IDLE;
                end
                default: seq_reg <= AU_SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_reg <= 1'b0;
        else if (start)
            busy_reg <= 1'b1;
        else if (eng_done)
            busy_reg <= 1'b0;
    end

    always_ff @(posedge pclk)
    begin
        if (eng_done)
        begin
            data_reg[0] <= eng_q[7:0];
            data_reg[1] <= eng_q[15:8];
            data_reg[2] <= eng_q[23:16];
            data_reg[3] <= eng_q[31:24];
            data_reg[4] <= eng_r[7:0];
            data_reg[5] <= eng_r[15:8];
        end
        else if (wr && is_data && !busy_reg)
            data_reg[idx] <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_reg <= status_rst_val[`AU_ERR_BIT];
        else if (acc && is_data && busy_reg)
            err_reg <= 1'b1;
        else if (rd && is_stat && !busy_reg)
            err_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_reg <= status_rst_val[`AU_OVF_BIT];
        else if (eng_done)
            ovf_reg <= eng_ovf;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr <= `AU_OFF_BYTE5 && paddr[1:0] == 2'b00)
                prdata <= {24'h000000, data_reg[paddr[4:2]]};
            else if (paddr == `AU_OFF_STATUS)
                prdata <= {24'h000000, err_reg, ovf_reg, 6'h00};
            else
                prdata <= 32'h00000000;
        end
    end

    au_engine u_engine
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start),
        .op      (start_op),
        .opa     ({data_reg[3], data_reg[2], data_reg[1], data_reg[0]}),
        .opb     ({pwdata[7:0], data_reg[4]}),
        .done    (eng_done),
        .res_q   (eng_q),
        .res_r   (eng_r),
        .ovf     (eng_ovf)
    );

    property p_err_set;
        @(posedge pclk) disable iff (!presetn)
        (acc && is_data && busy_reg) |=> err_reg;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    property p_err_clr;
        @(posedge pclk) disable iff (!presetn)
        (rd && is_stat && !busy_reg && !(acc && is_data)) |=> !err_reg;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");

    property p_div32_time;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_DIV32) |-> ##17 eng_done;
    endproperty
    a_div32_time: assert property (p_div32_time) else $error("div32 latency");

    property p_div16_time;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_DIV16) |-> ##9 eng_done;
    endproperty
    a_div16_time: assert property (p_div16_time) else $error("div16 latency");

    property p_mul_time;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_MUL) |-> ##11 eng_done;
    endproperty
    a_mul_time: assert property (p_mul_time) else $error("mul latency");

    property p_ovf_upd;
        @(posedge pclk) disable iff (!presetn)
        eng_done |=> (ovf_reg == $past(eng_ovf));
    endproperty
    a_ovf_upd: assert property (p_ovf_upd) else $error("overflow not updated");

    property p_stat_low;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == `AU_OFF_STATUS) |=> (prdata[5:0] == 6'h00);
    endproperty
    a_stat_low: assert property (p_stat_low) else $error("status low bits set");

    property p_no_start;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && idx != 3'd5) |-> !start;
    endproperty
    a_no_start: assert property (p_no_start) else $error("start without byte5");

    property p_div32_quiet;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_DIV32) |=> !eng_done [*8];
    endproperty
    a_div32_quiet: assert property (p_div32_quiet) else $error("div32 ended early");

    property p_div16_quiet;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_DIV16) |=> !eng_done [*8];
    endproperty
    a_div16_quiet: assert property (p_div16_quiet) else $error("div16 ended early");

    property p_mul_quiet;
        @(posedge pclk) disable iff (!presetn)
        (start && start_op == AU_OP_MUL) |=> !eng_done [*8];
    endproperty
    a_mul_quiet: assert property (p_mul_quiet) else $error("mul ended early");

    property p_busy_rise;
        @(posedge pclk) disable iff (!presetn)
        start |=> busy_reg;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

    property p_busy_fall;
        @(posedge pclk) disable iff (!presetn)
        eng_done |=> !busy_reg;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy not dropped");

    property p_busy_gate;
        @(posedge pclk) disable iff (!presetn)
        busy_reg |-> !start;
    endproperty
    a_busy_gate: assert property (p_busy_gate) else $error("start while busy");

    property p_div32_start;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && !busy_reg && idx == 3'd5 && seq_reg == AU_SEQ_W01234)
            |-> (start && start_op == AU_OP_DIV32);
    endproperty
    a_div32_start: assert property (p_div32_start) else $error("div32 not started");

    property p_div16_start;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && !busy_reg && idx == 3'd5 && seq_reg == AU_SEQ_W014)
            |-> (start && start_op == AU_OP_DIV16);
    endproperty
    a_div16_start: assert property (p_div16_start) else $error("div16 not started");

    property p_mul_start;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && !busy_reg && idx == 3'd5 && seq_reg == AU_SEQ_W04 && mul_pend_reg)
            |-> (start && start_op == AU_OP_MUL);
    endproperty
    a_mul_start: assert property (p_mul_start) else $error("mul not started");

    property p_restart0;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && !busy_reg && idx == 3'd0) |=> (seq_reg == AU_SEQ_W0);
    endproperty
    a_restart0: assert property (p_restart0) else $error("tracker not restarted");

    property p_bad_order;
        @(posedge pclk) disable iff (!presetn)
        (wr && is_data && !busy_reg && idx == 3'd4 && seq_reg != AU_SEQ_W0123
            && seq_reg != AU_SEQ_W01 && seq_reg != AU_SEQ_W0) |=> (seq_reg == AU_SEQ_IDLE);
    endproperty
    a_bad_order: assert property (p_bad_order) else $error("bad order kept");

    property p_seq_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr && is_data && !busy_reg) |=> ($stable(seq_reg) && $stable(mul_pend_reg));
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("tracker moved in gap");

    property p_result_load;
        @(posedge pclk) disable iff (!presetn)
        eng_done |=> (data_reg[0] == $past(eng_q[7:0]) && data_reg[3] == $past(eng_q[31:24])
            && data_reg[4] == $past(eng_r[7:0]));
    endproperty
    a_result_load: assert property (p_result_load) else $error("results not loaded");

    property p_err_hold;
        @(posedge pclk) disable iff (!presetn)
        (!(acc && is_data && busy_reg) && !(rd && is_stat && !busy_reg)) |=> $stable(err_reg);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag moved");

    property p_ovf_hold;
        @(posedge pclk) disable iff (!presetn)
        !eng_done |=> $stable(ovf_reg);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag moved");

    property p_stat_bits;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == `AU_OFF_STATUS)
            |=> (prdata[7] == $past(err_reg) && prdata[6] == $past(ovf_reg));
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("status flags wrong");
endmodule // au_top

// *** tb/au_host.sv ***
`timescale 1ns/1ps
// host core model: issues one apb byte access at a time
module au_host
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data line no longer shows the last value
        pwdata <= ~pwdata;
    endtask
endmodule // au_host

// *** tb/multiply_divide_unit_tb.sv ***
`timescale 1ns/1ps
`include "au_params.svh"
module multiply_divide_unit_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    int          errors;
    int          num_checks;

    au_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));
    au_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic end_sim;
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bad write order, plain read back, unmapped address
    task automatic misc;
        int k[$];
        logic [31:0] q;
        logic e;
        k = {0, 1, 2, 4, 5};
        foreach (k[i])
            host.xfer(12'(4 * k[i]), 1'b1, 8'h5a, q, e);
        #1;
        @(posedge pclk);
        #1;
        chk({31'h0, busy}, 32'h0);
        host.xfer(`AU_OFF_BYTE2, 1'b0, 8'h00, q, e);
        chk(q, 32'h0000005a);
        host.xfer(12'h01c, 1'b0, 8'h00, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask

    // one calculation: load, time it, check status and results
    task automatic run(input int kind, input logic [31:0] a, input logic [15:0] b,
                       input bit gap, input int cyc, input bit poke);
        int ord[$];
        int rds[$];
        logic [47:0] v;
        logic [47:0] res;
        logic [31:0] q;
        logic e;
        logic ovf;
        time t0;
        int n;
        v = {b, a};
        n = 0;
        case (kind)
            0: ord = {0, 1, 2, 3, 4, 5};
            1: ord = {0, 1, 4, 5};
            default: ord = {0, 4, 1, 5};
        endcase
        rds = ord;
        if (kind == 2)
            rds = {0, 1, 2, 3};
        ovf = (kind == 2) ? ((32'(a[15:0]) * 32'(b)) > 32'h0000ffff) : (b == 16'h0);
        res = '0;
        if (kind == 2)
            res[31:0] = 32'(a[15:0]) * 32'(b);
        else if (b != 16'h0)
        begin
            res[31:0] = (kind == 0) ? a / 32'(b) : 32'(a[15:0] / b);
            res[47:32] = (kind == 0) ? 16'(a % 32'(b)) : a[15:0] % b;
        end
        foreach (ord[i])
        begin
            if (gap)
                host.xfer(`AU_OFF_STATUS, 1'b0, 8'h00, q, e);
            host.xfer(12'(4 * ord[i]), 1'b1, v[8 * ord[i] +: 8], q, e);
        end
        t0 = $time;
        if (poke)
            host.xfer(`AU_OFF_BYTE0, 1'b0, 8'h00, q, e);
        #1;
        while (busy !== 1'b0 && n < 64)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(32'(($time - t0) / 8), 32'(cyc));
        host.xfer(`AU_OFF_STATUS, 1'b0, 8'h00, q, e);
        chk(q, {24'h0, poke, ovf, 6'h00});
        if (poke)
        begin
            host.xfer(`AU_OFF_STATUS, 1'b0, 8'h00, q, e);
            chk(q, {24'h0, 1'b0, ovf, 6'h00});
        end
        if (kind == 2 || b != 16'h0)
        begin
            foreach (rds[i])
            begin
                if (gap)
                    host.xfer(`AU_OFF_STATUS, 1'b0, 8'h00, q, e);
                host.xfer(12'(4 * rds[i]), 1'b0, 8'h00, q, e);
                chk(q, {24'h0, res[8 * rds[i] +: 8]});
            end
        end
    endtask

    initial
    begin
        errors = 0;
        num_checks = 0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        misc;
        run(0, 32'hfedcba98, 16'h8765, 1'b0, 17, 1'b0);
        run(1, 32'h0000f00d, 16'h0123, 1'b1, 9, 1'b0);
        run(2, 32'h0000ff01, 16'hfe02, 1'b1, 11, 1'b0);
        run(2, 32'h000000ff, 16'h0101, 1'b0, 11, 1'b0);
        run(1, 32'h00001234, 16'h0000, 1'b0, 9, 1'b0);
        run(0, 32'h00000007, 16'h0003, 1'b0, 17, 1'b1);
        end_sim;
    end

    initial
    begin
        #100000;
        errors++;
        $display("[ERR] %0t run did not finish", $time);
        end_sim;
    end
endmodule // multiply_divide_unit_tb
